/* File: design/serial_port_defines.vh */
/*
 serial port constants: rates, frame codes, flow-control characters.
 assumes a 40 MHz system clock.
*/
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

`define CLOCK_HZ          40000000
`define OVERSAMPLE        16
// last divider count per 16x tick: clock / (rate * 16) rounded down, minus one
// sized to the 12-bit divider so nothing is cut silently
`define TICK_LIM_2400     12'h410
`define TICK_LIM_4800     12'h207
`define TICK_LIM_9600     12'h103
`define TICK_LIM_19200    12'h081
`define RATE_2400         2'h0
`define RATE_4800         2'h1
`define RATE_9600         2'h2
`define RATE_19200        2'h3
`define PARITY_NONE       2'h0
`define PARITY_EVEN       2'h1
`define PARITY_ODD        2'h2
`define FLOW_HW           1'h0
`define FLOW_SW           1'h1
`define CHAR_RESUME       8'h11
`define CHAR_STOP         8'h13
`define TICK_LAST         4'hF
`define TICK_MID          4'h7
`define BITS_7            4'h7
`define BITS_8            4'h8

`endif

/* File: design/baud_tick.v */
/*
 16x oversample tick generator; one-cycle enable pulse.
 assumes rate code from synchronised switches.
*/
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module baud_tick
(
   input  wire       clock,
   input  wire       srst,
   input  wire [1:0] rate_sel,
   output reg        tick
);
   reg  [11:0] count_reg;
   reg  [11:0] limit;

   always @*
   begin
      case (rate_sel)
         `RATE_2400: limit = `TICK_LIM_2400;
         `RATE_4800: limit = `TICK_LIM_4800;
         `RATE_9600: limit = `TICK_LIM_9600;
         default:    limit = `TICK_LIM_19200;
      endcase
   end

   // a rate change mid-count just lands on the new limit
   always @(posedge clock)
   begin
      if (srst)
      begin
         count_reg <= 12'h000;
         tick      <= 1'b0;
      end
      else if (count_reg >= limit)
      begin
         count_reg <= 12'h000;
         tick      <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 12'h001;
         tick      <= 1'b0;
      end
   end
endmodule

/* File: design/serial_port_flow_control.v */
/*
 printer serial port: receiver, transmitter, busy/ready and xon/xoff flow control.
 assumes switches and line pins are asynchronous; user side is on clock.
*/
// Operation
// - rates 2400/4800/9600/19200, 7 or 8 data bits, none/even/odd parity.
// - flow mode, length, rate, parity come from switch inputs.
// - software mode: on entering busy send 13h.
// - software mode: on leaving busy send 11h.
// - hardware mode: hold each character while host ready is low.
// - software mode: host ready input is ignored.
// - busy output high while busy, low while accepting.
// - differential variant uses same busy output and host ready input.
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module serial_port_flow_control
(
   input  wire       clock,
   input  wire       srst,
   input  wire       sw_flow,
   input  wire       sw_eight_bits,
   input  wire [1:0] sw_rate,
   input  wire [1:0] sw_parity,
   input  wire       rx_line,
   input  wire       host_ready,
   output reg        tx_line,
   output reg        busy_out,
   input  wire       printer_busy,
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   output reg        tx_ready,
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   output reg        rx_parity_error,
   output reg        rx_frame_error
);
   localparam S_IDLE   = 5'h01;
   localparam S_START  = 5'h02;
   localparam S_DATA   = 5'h04;
   localparam S_PARITY = 5'h08;
   localparam S_STOP   = 5'h10;

   // two-flop synchronisers for every asynchronous input
   reg  [6:0] sync1_reg;
   reg  [6:0] sync2_reg;
   wire [6:0] async_in = {sw_flow, sw_eight_bits, sw_rate, sw_parity[0], rx_line, host_ready};
   reg        par1_reg;
   reg        par2_reg;
   always @(posedge clock)
   begin
      if (srst)
      begin
         sync1_reg <= 7'h07;
         sync2_reg <= 7'h07;
         par1_reg  <= 1'b0;
         par2_reg  <= 1'b0;
      end
      else
      begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
         par1_reg  <= sw_parity[1];
         par2_reg  <= par1_reg;
      end
   end
   wire       flow_sw  = sync2_reg[6];
   wire       eight    = sync2_reg[5];
   wire [1:0] rate     = sync2_reg[4:3];
   wire [1:0] parity   = {par2_reg, sync2_reg[2]};
   wire       rx_s     = sync2_reg[1];
   wire       ready_s  = sync2_reg[0];
   wire [3:0] nbits    = eight ? `BITS_8 : `BITS_7;
   wire       par_on   = (parity == `PARITY_EVEN) || (parity == `PARITY_ODD);
   wire       par_odd  = (parity == `PARITY_ODD);

   wire tick;
   baud_tick u_tick
   (
      .clock    (clock),
      .srst     (srst),
      .rate_sel (rate),
      .tick     (tick)
   );

   // busy line straight from the printer state
   always @(posedge clock)
   begin
      if (srst)
         busy_out <= 1'b1;
      else
         busy_out <= printer_busy;
   end

   // receiver, mid-bit sampling at 16x
   reg [4:0] rx_state_reg;
   reg [3:0] rx_tick_reg;
   reg [3:0] rx_bit_reg;
   reg [7:0] rx_shift_reg;
   reg       rx_par_reg;
   always @(posedge clock)
   begin
      if (srst)
      begin
         rx_state_reg    <= S_IDLE;
         rx_tick_reg     <= 4'h0;
         rx_bit_reg      <= 4'h0;
         rx_shift_reg    <= 8'h00;
         rx_par_reg      <= 1'b0;
         rx_data         <= 8'h00;
         rx_valid        <= 1'b0;
         rx_parity_error <= 1'b0;
         rx_frame_error  <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (tick)
         begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            case (rx_state_reg)
               S_IDLE:
                  if (!rx_s)
                  begin
                     rx_state_reg <= S_START;
                     rx_tick_reg  <= 4'h0;
                  end
               S_START:
                  if (rx_tick_reg == `TICK_MID)
                  begin
                     rx_tick_reg  <= 4'h0;
                     rx_bit_reg   <= 4'h0;
                     rx_shift_reg <= 8'h00;
                     rx_par_reg   <= 1'b0;
                     // glitch shorter than half a bit is dropped
                     rx_state_reg <= rx_s ? S_IDLE : S_DATA;
                  end
               S_DATA:
                  if (rx_tick_reg == `TICK_LAST)
                  begin
                     rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                     rx_par_reg   <= rx_par_reg ^ rx_s;
                     rx_bit_reg   <= rx_bit_reg + 4'h1;
                     if (rx_bit_reg == nbits - 4'h1)
                        rx_state_reg <= par_on ? S_PARITY : S_STOP;
                  end
               S_PARITY:
                  if (rx_tick_reg == `TICK_LAST)
                  begin
                     rx_par_reg   <= rx_par_reg ^ rx_s ^ par_odd;
                     rx_state_reg <= S_STOP;
                  end
               S_STOP:
                  if (rx_tick_reg == `TICK_LAST)
                  begin
                     rx_data         <= eight ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
                     rx_valid        <= 1'b1;
                     rx_parity_error <= par_on & rx_par_reg;
                     rx_frame_error  <= !rx_s;
                     rx_state_reg    <= S_IDLE;
                  end
               default:
                  rx_state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // flow character requests, latched once per busy edge
   reg busy_seen_reg;
   reg xoff_pend_reg;
   reg xon_pend_reg;
   wire busy_rise = printer_busy & !busy_seen_reg;
   wire busy_fall = !printer_busy & busy_seen_reg;

   reg [4:0] tx_state_reg;
   reg [3:0] tx_tick_reg;
   reg [3:0] tx_bit_reg;
   reg [7:0] tx_shift_reg;
   reg       tx_par_reg;
   // only start between frames, so a flow character never splits one
   wire idle_go  = tx_state_reg[0] & tick & (tx_tick_reg == `TICK_LAST);
   wire send_flw = idle_go & flow_sw & (xoff_pend_reg | xon_pend_reg);
   wire data_ok  = flow_sw | ready_s;
   wire send_dat = idle_go & !send_flw & tx_valid & data_ok;

   always @(posedge clock)
   begin
      if (srst)
      begin
         busy_seen_reg <= 1'b0;
         xoff_pend_reg <= 1'b0;
         xon_pend_reg  <= 1'b0;
      end
      else
      begin
         busy_seen_reg <= printer_busy;
         // a newer edge replaces an unsent opposite character
         if (busy_rise & flow_sw)
         begin
            xoff_pend_reg <= 1'b1;
            xon_pend_reg  <= 1'b0;
         end
         else if (busy_fall & flow_sw)
         begin
            xon_pend_reg  <= 1'b1;
            xoff_pend_reg <= 1'b0;
         end
         else if (send_flw | !flow_sw)
         begin
            xoff_pend_reg <= 1'b0;
            xon_pend_reg  <= 1'b0;
         end
      end
   end

   always @(posedge clock)
   begin
      if (srst)
      begin
         tx_state_reg <= S_IDLE;
         tx_tick_reg  <= 4'h0;
         tx_bit_reg   <= 4'h0;
         tx_shift_reg <= 8'h00;
         tx_par_reg   <= 1'b0;
         tx_line      <= 1'b1;
         tx_ready     <= 1'b0;
      end
      else
      begin
         tx_ready <= send_dat;
         if (tick)
         begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `TICK_LAST)
            begin
               case (tx_state_reg)
                  S_IDLE:
                     if (send_flw | send_dat)
                     begin
                        tx_shift_reg <= send_flw ? (xoff_pend_reg ? `CHAR_STOP : `CHAR_RESUME) : tx_data;
                        tx_par_reg   <= par_odd;
                        tx_bit_reg   <= 4'h0;
                        tx_line      <= 1'b0;
                        tx_state_reg <= S_DATA;
                     end
                  S_DATA:
                  begin
                     tx_line      <= tx_shift_reg[0];
                     tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                     tx_bit_reg   <= tx_bit_reg + 4'h1;
                     if (tx_bit_reg == nbits - 4'h1)
                        tx_state_reg <= par_on ? S_PARITY : S_STOP;
                  end
                  S_PARITY:
                  begin
                     tx_line      <= tx_par_reg;
                     tx_state_reg <= S_STOP;
                  end
                  S_STOP:
                  begin
                     tx_line      <= 1'b1;
                     tx_state_reg <= S_IDLE;
                  end
                  default:
                  begin
                     tx_line      <= 1'b1;
                     tx_state_reg <= S_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule

/* File: sim/port_chk.sv */
/*
 assertions on the printer serial port pins.
 assumes binding onto serial_port_flow_control, one clock.
*/
`timescale 1ns/1ps
module port_chk
(
   input wire       clock,
   input wire       srst,
   input wire       sw_flow,
   input wire       sw_eight_bits,
   input wire       host_ready,
   input wire       printer_busy,
   input wire       tx_line,
   input wire       busy_out,
   input wire       tx_ready,
   input wire       rx_valid,
   input wire [7:0] rx_data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // five edges covers the two-flop synchroniser plus the take edge
   sequence host_held_off;
      (!sw_flow && !host_ready)[*5];
   endsequence
   sequence start_bit_hold;
      (!tx_line)[*8];
   endsequence
   AST_BUSY_FOLLOWS: assert property ($past(!srst) |-> busy_out == $past(printer_busy))
      else $error("busy output does not follow printer busy");
   AST_RESET_STATE: assert property ($past(srst) |-> tx_line && busy_out && !tx_ready && !rx_valid)
      else $error("outputs wrong just after reset");
   AST_HOLD_OFF: assert property (host_held_off |=> !tx_ready)
      else $error("character taken while host not ready");
   AST_START_LOW: assert property (tx_ready |-> !tx_line)
      else $error("no start bit with take");
   AST_START_HOLD: assert property (tx_ready |-> start_bit_hold)
      else $error("start bit too short");
   AST_TX_PULSE: assert property (tx_ready |=> !tx_ready)
      else $error("take pulse longer than one cycle");
   AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
      else $error("receive pulse longer than one cycle");
   AST_RX_BIT7: assert property (rx_valid && !sw_eight_bits |-> !rx_data[7])
      else $error("bit 7 set in seven bit word");
endmodule
bind serial_port_flow_control port_chk chk_u (.clock(clock), .srst(srst), .sw_flow(sw_flow),
   .sw_eight_bits(sw_eight_bits), .host_ready(host_ready), .printer_busy(printer_busy), .tx_line(tx_line),
   .busy_out(busy_out), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

/* File: sim/host_port.sv */
/*
 behavioural host serial port: frames in both directions, ready line.
 assumes the frame settings are set by the bench to match the switches.
*/
`timescale 1ns/1ps
module host_port #(parameter BIT_CYC = 2080)
(
   input  wire clock,
   input  wire tx_line,
   input  wire busy_out,
   output reg  rx_line,
   output reg  host_ready
);
   integer   nbits, par, sw, got_n, k;
   reg [7:0] got, w;
   reg       bad, stopped, q;
   initial
   begin
      rx_line = 1'b1;
      host_ready = 1'b0;
      nbits = 8; par = 1; sw = 0; got_n = 0; got = 8'h00; bad = 1'b0; stopped = 1'b0;
   end
   task bit_out(input b);
   begin
      rx_line <= b;
      repeat (BIT_CYC) @(posedge clock);
   end
   endtask
   task send_char(input [7:0] d);
      integer i;
      reg     p;
   begin
      p = (par == 2);
      for (i = 0; i < nbits; i = i + 1) p = p ^ d[i];
      @(posedge clock);
      while (sw ? stopped : busy_out) @(posedge clock);
      bit_out(1'b0);
      for (i = 0; i < nbits; i = i + 1) bit_out(d[i]);
      if (par != 0) bit_out(p);
      bit_out(1'b1);
   end
   endtask
   // samples mid-bit; a short glitch is read as a real frame
   always
   begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge clock);
      w = 8'h00;
      q = (par == 2);
      for (k = 0; k < nbits; k = k + 1)
      begin
         repeat (BIT_CYC) @(posedge clock);
         w[k] = tx_line;
         q = q ^ tx_line;
      end
      if (par != 0)
      begin
         repeat (BIT_CYC) @(posedge clock);
         q = q ^ tx_line;
      end
      else q = 1'b0;
      repeat (BIT_CYC) @(posedge clock);
      bad = q | !tx_line;
      got = w;
      got_n = got_n + 1;
      if (w == 8'h13) stopped = 1'b1;
      if (w == 8'h11) stopped = 1'b0;
   end
endmodule

/* File: sim/testbench.sv */
/*
 self-checking bench: hardware hold-off, frames both ways, xon/xoff.
 assumes 40 MHz clock, host model at 19200 bit/s.
*/
`timescale 1ns/1ps
module testbench;
   reg        clock, srst, sw_flow, sw_eight_bits, printer_busy, tx_valid;
   reg  [1:0] sw_rate, sw_parity;
   reg  [7:0] tx_data;
   wire       rx_line, host_ready, tx_line, busy_out, tx_ready, rx_valid, rx_parity_error, rx_frame_error;
   wire [7:0] rx_data;
   integer    errors, checks, rdy_n, rxv_n, i, rate_code, cyc;
   serial_port_flow_control dut_u (.clock(clock), .srst(srst), .sw_flow(sw_flow), .sw_eight_bits(sw_eight_bits),
      .sw_rate(sw_rate), .sw_parity(sw_parity), .rx_line(rx_line), .host_ready(host_ready), .tx_line(tx_line),
      .busy_out(busy_out), .printer_busy(printer_busy), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_error(rx_parity_error),
      .rx_frame_error(rx_frame_error));
   host_port #(.BIT_CYC(2080)) host_u (.clock(clock), .tx_line(tx_line), .busy_out(busy_out),
      .rx_line(rx_line), .host_ready(host_ready));
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      if (tx_ready === 1'b1) rdy_n <= rdy_n + 1;
      if (rx_valid === 1'b1) rxv_n <= rxv_n + 1;
   end
   task check(input [8*12-1:0] name, input [15:0] exp, input [15:0] seen);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("unexpected %0s expected %h seen %h", name, exp, seen);
      end
   end
   endtask
   task wait_host(input integer n);
      for (i = 0; i < 30000 && host_u.got_n < n; i = i + 1) @(posedge clock);
   endtask
   task give_verdict;
   begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (110000) @(posedge clock);
      errors = errors + 1;
      give_verdict;
   end
   initial
   begin
      errors = 0; checks = 0; rdy_n = 0; rxv_n = 0;
      srst = 1'b1; sw_flow = 1'b0; sw_eight_bits = 1'b1; sw_rate = 2'h3; sw_parity = 2'h1;
      printer_busy = 1'b0; tx_valid = 1'b0; tx_data = 8'h00;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      repeat (4) @(posedge clock);
      tx_data <= 8'hA5;
      tx_valid <= 1'b1;
      // longer than one bit slot, so a take that ignored ready would show
      repeat (2500) @(posedge clock);
      check("held off", 8'h00, rdy_n);
      host_u.host_ready <= 1'b1;
      for (i = 0; i < 3000 && rdy_n == 0; i = i + 1) @(posedge clock);
      tx_valid <= 1'b0;
      host_u.send_char(8'h3C);
      wait_host(1);
      check("tx char", 8'hA5, host_u.got);
      check("tx parity", 8'h00, host_u.bad);
      check("rx char", 8'h3C, rx_data);
      check("rx errors", 8'h00, {rx_parity_error, rx_frame_error});
      $display("test hardware flow done");
      sw_flow <= 1'b1; sw_eight_bits <= 1'b0; sw_parity <= 2'h2;
      host_u.host_ready <= 1'b0;
      host_u.sw = 1; host_u.nbits = 7; host_u.par = 2;
      repeat (10) @(posedge clock);
      printer_busy <= 1'b1;
      host_u.send_char(8'h5A);
      check("rx 7 bit", 8'h5A, rx_data);
      check("rx odd", 8'h00, {rx_parity_error, rx_frame_error});
      wait_host(2);
      check("stop char", 8'h13, host_u.got);
      check("busy out", 8'h01, busy_out);
      // xon and the data queued behind it go out with no parity bit
      sw_parity <= 2'h0;
      host_u.par = 0;
      tx_data <= 8'h4B;
      tx_valid <= 1'b1;
      printer_busy <= 1'b0;
      wait_host(3);
      check("resume char", 8'h11, host_u.got);
      check("xon parity", 8'h00, host_u.bad);
      check("busy out", 8'h00, busy_out);
      // host ready stays low: software mode must still send the data
      for (i = 0; i < 30000 && rdy_n < 2; i = i + 1) @(posedge clock);
      tx_valid <= 1'b0;
      wait_host(4);
      check("sw data", 8'h4B, host_u.got);
      check("frames", 8'h04, host_u.got_n);
      check("takes", 8'h02, rdy_n);
      check("rx count", 8'h02, rxv_n);
      $display("test software flow done");
      // frames at the slower rates would take too long; measure the tick instead
      for (rate_code = 0; rate_code < 4; rate_code = rate_code + 1)
      begin
         sw_rate <= rate_code[1:0];
         repeat (4) @(posedge clock);
         for (i = 0; i < 1100 && dut_u.u_tick.tick !== 1'b1; i = i + 1) @(posedge clock);
         @(posedge clock);
         cyc = 1;
         while (cyc < 1100 && dut_u.u_tick.tick !== 1'b1)
         begin
            @(posedge clock);
            cyc = cyc + 1;
         end
         check("tick period", 40000000 / ((2400 << rate_code) * 16), cyc);
      end
      $display("test rates done");
      give_verdict;
   end
endmodule
